// *** design/ssw_ctrl.sv ***
// Chip-select decode, full-width write detect, data bus drive and sleep.
// Assumes the bus master meets setup and hold around each rising edge.
//
// What this block does
// - Selected only when selects read low-high-low.
// - Full write on global write, or on all lanes with the lane write gate low.
// - Bus stays high-Z after write until read.
// - Data lines high-Z on leaving sleep.
`timescale 1ns/10ps

module ssw_ctrl
	import ssw_pkg::*;
#(
	parameter int LANES = SSW_LANES_DEF
)
(
	input  wire logic             i_clk,
	input  wire logic             i_rst_b,
	input  wire logic             i_primary_chip_select_n,
	input  wire logic             i_expansion_select_high,
	input  wire logic             i_expansion_select_low_n,
	input  wire logic             i_all_lanes_write_n,
	input  wire logic             i_lane_write_gate_n,
	input  wire logic [LANES-1:0] i_lane_write_select_n,
	input  wire logic             i_processor_addr_strobe_n,
	input  wire logic             i_controller_addr_strobe_n,
	input  wire logic             i_output_enable_n,
	input  wire logic             i_sleep_request,
	output logic                  o_selected,
	output logic                  o_full_write,
	output logic                  o_read_start,
	output logic                  o_data_oe_b,
	output logic                  o_sleeping
);

	if (LANES < 1)
	begin : g_lanes_chk
		$error("LANES must be at least one");
	end

	typedef struct packed {
		logic [1:0] oe_sync;
		logic [1:0] zz_sync;
		logic       selected;
		logic       full_write;
		logic       read_start;
		logic       drive;
		logic       data_oe_b;
		logic       sleeping;
	} ssw_state_t;

	ssw_state_t st_r;
	ssw_state_t st_nxt;

	function automatic logic ssw_sel(input logic c1n, input logic c2,
		input logic c3n);
		ssw_sel = !c1n && c2 && !c3n;
	endfunction

	logic sel_now;
	logic strobe_now;
	logic wr_now;
	logic sleep_s;
	logic oe_s;

	always_comb
	begin
		st_nxt = st_r;
		sel_now = ssw_sel(i_primary_chip_select_n, i_expansion_select_high,
			i_expansion_select_low_n);
		strobe_now = !i_processor_addr_strobe_n ||
			!i_controller_addr_strobe_n;
		wr_now = sel_now && (!i_all_lanes_write_n ||
			(!i_lane_write_gate_n && (i_lane_write_select_n == '0)));
		st_nxt.oe_sync = {st_r.oe_sync[0], !i_output_enable_n};
		st_nxt.zz_sync = {st_r.zz_sync[0], i_sleep_request};
		sleep_s = st_r.zz_sync[1];
		oe_s = st_r.oe_sync[1];
		st_nxt.sleeping = sleep_s;
		st_nxt.selected = sel_now && !sleep_s;
		st_nxt.full_write = wr_now && !sleep_s;
		// no read start in the sleep exit cycle.
		st_nxt.read_start = sel_now && strobe_now && !wr_now && !sleep_s &&
			!st_r.sleeping;
		if (sleep_s || st_r.sleeping)
		begin
			st_nxt.drive = 1'b0;
		end
		else if (wr_now)
		begin
			st_nxt.drive = 1'b0;
		end
		else if (sel_now && strobe_now)
		begin
			st_nxt.drive = 1'b1;
		end
		else if (strobe_now)
		begin
			st_nxt.drive = 1'b0;
		end
		st_nxt.data_oe_b = !(st_nxt.drive && oe_s && !sleep_s);
	end

	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			st_r <= '0;
			st_r.data_oe_b <= SSW_RST_OE_B;
			st_r.drive <= SSW_RST_DRIVE;
			st_r.selected <= SSW_RST_SEL;
		end
		else
			st_r <= st_nxt;
	end

	assign o_selected = st_r.selected;
	assign o_full_write = st_r.full_write;
	assign o_read_start = st_r.read_start;
	assign o_data_oe_b = st_r.data_oe_b;
	assign o_sleeping = st_r.sleeping;

	sequence s_write;
		o_full_write;
	endsequence

	sequence s_read;
		o_read_start;
	endsequence

	property p_sel_decode;
		@(posedge i_clk) disable iff (!i_rst_b)
		(i_primary_chip_select_n && !st_r.zz_sync[1]) |=> !o_selected;
	endproperty
	a_sel_decode: assert property (p_sel_decode)
		else $error("selected with primary select high");

	property p_sel_ok;
		@(posedge i_clk) disable iff (!i_rst_b)
		(!i_primary_chip_select_n && i_expansion_select_high &&
		 !i_expansion_select_low_n && !st_r.zz_sync[1]) |=> o_selected;
	endproperty
	a_sel_ok: assert property (p_sel_ok)
		else $error("not selected with valid pattern");

	property p_gw;
		@(posedge i_clk) disable iff (!i_rst_b)
		(ssw_sel(i_primary_chip_select_n, i_expansion_select_high,
		 i_expansion_select_low_n) && !i_all_lanes_write_n &&
		 !st_r.zz_sync[1]) |=> o_full_write;
	endproperty
	a_gw: assert property (p_gw)
		else $error("global write not seen");

	property p_lanes;
		@(posedge i_clk) disable iff (!i_rst_b)
		(i_all_lanes_write_n && i_lane_write_gate_n) |=> !o_full_write;
	endproperty
	a_lanes: assert property (p_lanes)
		else $error("write without gate");

	property p_hz_after_write;
		@(posedge i_clk) disable iff (!i_rst_b)
		s_write |-> o_data_oe_b;
	endproperty
	a_hz_after_write: assert property (p_hz_after_write)
		else $error("bus driven after write");

	property p_read_resume;
		@(posedge i_clk) disable iff (!i_rst_b)
		(s_read ##0 $past(st_r.oe_sync[1]) && !o_sleeping) |-> !o_data_oe_b;
	endproperty
	a_read_resume: assert property (p_read_resume)
		else $error("read did not drive bus");

	property p_hz_hold;
		@(posedge i_clk) disable iff (!i_rst_b)
		(s_write ##1 !o_read_start) |-> o_data_oe_b;
	endproperty
	a_hz_hold: assert property (p_hz_hold)
		else $error("bus driven after write without a read");

	property p_unsel_strobe;
		@(posedge i_clk) disable iff (!i_rst_b)
		((!i_processor_addr_strobe_n || !i_controller_addr_strobe_n) &&
		 !ssw_sel(i_primary_chip_select_n, i_expansion_select_high,
		 i_expansion_select_low_n) && !st_r.zz_sync[1]) |=>
		(o_data_oe_b && !o_read_start);
	endproperty
	a_unsel_strobe: assert property (p_unsel_strobe)
		else $error("deselected strobe started a read");

	property p_desel_write;
		@(posedge i_clk) disable iff (!i_rst_b)
		(!ssw_sel(i_primary_chip_select_n, i_expansion_select_high,
		 i_expansion_select_low_n) && !i_all_lanes_write_n) |=>
		!o_full_write;
	endproperty
	a_desel_write: assert property (p_desel_write)
		else $error("write taken while deselected");

	property p_sleep_quiet;
		@(posedge i_clk) disable iff (!i_rst_b)
		o_sleeping |-> (o_data_oe_b && !o_read_start && !o_full_write);
	endproperty
	a_sleep_quiet: assert property (p_sleep_quiet)
		else $error("activity while sleeping");

	property p_sleep_exit;
		@(posedge i_clk) disable iff (!i_rst_b)
		$fell(o_sleeping) |-> o_data_oe_b;
	endproperty
	a_sleep_exit: assert property (p_sleep_exit)
		else $error("bus driven at sleep exit");

	property p_sleep_sync;
		@(posedge i_clk) disable iff (!i_rst_b)
		$rose(st_r.zz_sync[1]) |=> o_sleeping ##1 (o_data_oe_b || !o_sleeping);
	endproperty
	a_sleep_sync: assert property (p_sleep_sync)
		else $error("sleep not followed");

endmodule

// *** design/ssw_pkg.sv ***
// Constants for the select, write and sleep front end of the SRAM bus.
// Assumes a single rising-edge clock and active-low asynchronous reset.
package ssw_pkg;

	localparam int SSW_LANES_DEF = 4;
	localparam logic SSW_RST_DRIVE = 1'b0;
	localparam logic SSW_RST_SEL = 1'b0;
	localparam logic SSW_RST_OE_B = 1'b1;

endpackage

// *** bench/ssw_master.sv ***
// Bus master model: drives the chip selects and the sleep request.
// Assumes the bench sets the wanted pattern and sleep wish off the edge.
`timescale 1ns/10ps
module ssw_master
(
	input  wire logic       i_clk,
	input  wire logic [2:0] i_pat,
	input  wire logic       i_zz,
	output logic [2:0]      o_ce,
	output logic            o_zz
);
	assign o_ce = i_zz ? 3'h7 : i_pat;
	always @(negedge i_clk)
		o_zz <= i_zz && (o_ce == 3'h7);
endmodule

// *** bench/tb_top.sv ***
// Testbench for the select, write and sleep front end.
// Assumes the design and the bus master model are compiled first.
`timescale 1ns/10ps
module tb_top;
	logic i_clk = 0, i_rst_b = 0, gw_n = 1, gate_n = 1, oe_n = 1, zz = 0;
	logic [1:0] st_n = 2'h3;
	logic [2:0] pat = 3'h7, ce;
	logic [3:0] ln_n = 4'hf;
	logic sel, fw, rs, oeb, slp, zzp;
	int num_errors = 0, tests_run = 0, k;
	always #12.5 i_clk = ~i_clk;
	ssw_master u_ssw_master(.i_clk(i_clk), .i_pat(pat), .i_zz(zz),
		.o_ce(ce), .o_zz(zzp));
	ssw_ctrl u_ssw_ctrl(.i_clk(i_clk), .i_rst_b(i_rst_b),
		.i_primary_chip_select_n(ce[2]), .i_expansion_select_high(ce[1]),
		.i_expansion_select_low_n(ce[0]), .i_all_lanes_write_n(gw_n),
		.i_lane_write_gate_n(gate_n), .i_lane_write_select_n(ln_n),
		.i_processor_addr_strobe_n(st_n[1]),
		.i_controller_addr_strobe_n(st_n[0]), .i_output_enable_n(oe_n),
		.i_sleep_request(zzp), .o_selected(sel), .o_full_write(fw),
		.o_read_start(rs), .o_data_oe_b(oeb), .o_sleeping(slp));
	task automatic final_report;
		$display("checks %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic v, input logic e);
		tests_run++;
		if (v !== e)
		begin
			num_errors++;
			$display("mismatch %s expected %b seen %b", n, e, v);
		end
	endtask
	task automatic step(input logic [2:0] p, input logic g, input logic b,
		input logic [3:0] l, input logic [1:0] s);
		@(negedge i_clk);
		pat <= p;
		gw_n <= g;
		gate_n <= b;
		ln_n <= l;
		st_n <= s;
		@(posedge i_clk);
		#1;
	endtask
	task automatic t_sel;
		for (int i = 0; i < 8; i++)
		begin
			step(i, 1, 1, 4'hf, 2'h3);
			chk("selected", sel, i == 2);
		end
		$display("test select done");
	endtask
	task automatic t_write;
		logic [6:0] tw [6] = '{7'h5f, 7'h41, 7'h42, 7'h60, 7'h31, 7'h22};
		for (int i = 0; i < 6; i++)
		begin
			step(2, tw[i][5], tw[i][4], tw[i][3:0], 2'h3);
			chk("full_write", fw, tw[i][6]);
		end
		step(6, 0, 1, 4'hf, 2'h3);
		chk("full_write", fw, 1'b0);
		$display("test write done");
	endtask
	task automatic t_hiz;
		@(negedge i_clk) oe_n <= 0;
		repeat (3) step(7, 1, 1, 4'hf, 2'h3);
		step(2, 1, 1, 4'hf, 2'h1);
		chk("read_start", rs, 1'b1);
		chk("data_oe_b", oeb, 1'b0);
		step(2, 0, 1, 4'hf, 2'h3);
		repeat (2) step(7, 1, 1, 4'hf, 2'h3);
		chk("data_oe_b", oeb, 1'b1);
		step(2, 1, 1, 4'hf, 2'h2);
		chk("data_oe_b", oeb, 1'b0);
		@(negedge i_clk) oe_n <= 1;
		repeat (3) step(7, 1, 1, 4'hf, 2'h3);
		step(2, 1, 1, 4'hf, 2'h1);
		chk("data_oe_b", oeb, 1'b1);
		$display("test bus drive done");
	endtask
	task automatic t_sleep;
		@(negedge i_clk);
		oe_n <= 0;
		zz <= 1;
		for (k = 0; k < 8 && slp !== 1'b1; k++) step(2, 1, 1, 4'hf, 2'h1);
		chk("sleeping", slp, 1'b1);
		if (k == 8) final_report();
		@(negedge i_clk);
		zz <= 0;
		for (k = 0; k < 8 && slp !== 1'b0; k++) step(2, 1, 1, 4'hf, 2'h1);
		chk("data_oe_b", oeb, 1'b1);
		if (k == 8) final_report();
		step(2, 1, 1, 4'hf, 2'h1);
		chk("read_start", rs, 1'b1);
		chk("data_oe_b", oeb, 1'b0);
		$display("test sleep done");
	endtask
	initial
	begin
		repeat (10) @(negedge i_clk);
		i_rst_b = 1;
		t_sel();
		t_write();
		t_hiz();
		t_sleep();
		final_report();
	end
endmodule
